// *** psrb_pkg.sv ***
// shared constants, field layout and state types for the power register bank
package psrb_pkg;
    // bus addresses as full bytes, direction bit included
    localparam logic [7:0] WR_ADDR_BYTE = 8'h12;
    localparam logic [7:0] RD_ADDR_BYTE = 8'h13;
    // sub-addresses of the writable bytes
    localparam logic [1:0] SUB_REGULATOR = 2'h0;
    localparam logic [1:0] SUB_BACKLIGHT = 2'h1;
    localparam logic [1:0] SUB_LEVEL     = 2'h2;
    localparam logic [1:0] SUB_DIMMING   = 2'h3;
    localparam logic [7:0] SUB_LAST      = 8'h03;
    localparam int         NUM_REGS      = 4;
    localparam logic [7:0] REG_RESET     = 8'h00;
    // regulator control fields
    localparam int RC_LDO1    = 0;
    localparam int RC_LDO2    = 1;
    localparam int RC_LIGHT1  = 2;
    localparam int RC_LIGHT2  = 3;
    localparam int RC_LIGHT3  = 4;
    localparam int RC_EDGE_LO = 5;
    localparam int RC_EDGE_HI = 6;
    // backlight control fields
    localparam int BC_ON      = 0;
    localparam int BC_RAMP_LO = 1;
    localparam int BC_RAMP_HI = 2;
    localparam int BC_OP_LO   = 3;
    localparam int BC_OP_HI   = 4;
    localparam int BC_DIM_LO  = 5;
    localparam int BC_DIM_HI  = 6;
    localparam int BC_EDGE    = 7;
    // level and dimming fields
    localparam int LV_MSB     = 5;
    localparam int DM_DEN_LSB = 0;
    localparam int DM_NUM_LSB = 4;
    localparam int DM_W       = 4;
    // field encodings: edge time, ramp time, boost mode, dim clock
    localparam logic [1:0] EDGE_1NS = 2'b00;
    localparam logic [1:0] EDGE_8NS = 2'b11;
    localparam logic [1:0] RAMP_15MS = 2'b00;
    localparam logic [1:0] RAMP_1S85 = 2'b11;
    localparam logic [1:0] OP_CC_BOOST  = 2'b00;
    localparam logic [1:0] OP_HV_BOOST  = 2'b01;
    localparam logic [1:0] OP_PWM_BOOST = 2'b10;
    localparam logic [1:0] DIM_8K77 = 2'b00;
    localparam logic [1:0] DIM_2K19 = 2'b11;
    // charger fault codes
    localparam logic [1:0] FAULT_NONE    = 2'b00;
    localparam logic [1:0] FAULT_COLDHOT = 2'b01;
    localparam logic [1:0] FAULT_OVERTMP = 2'b10;
    localparam logic [1:0] FAULT_BATTERY = 2'b11;
    // low-battery limit: half an hour at the core clock
    localparam longint unsigned CLK_HZ       = 64'd20_000_000;
    localparam longint unsigned LOWBAT_S     = 64'd1800;
    localparam int              LOWBAT_W     = 36;
    localparam logic [LOWBAT_W-1:0] LOWBAT_CYCLES = LOWBAT_W'(LOWBAT_S * CLK_HZ);
    // serial engine states and byte phases
    typedef enum logic [2:0] {
        PSRB_IDLE, PSRB_RECV, PSRB_ACK_DRV, PSRB_ACK_HOLD, PSRB_SEND, PSRB_MACK, PSRB_REPEAT
    } psrb_state_t;
    typedef enum logic [1:0] {PSRB_PH_ADDR, PSRB_PH_SUB, PSRB_PH_DATA, PSRB_PH_DONE} psrb_phase_t;
endpackage

// *** psrb_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module psrb_sync #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } psrb_sync_t;
    psrb_sync_t s;
    psrb_sync_t next_s;

    // a bit changes only once stages two and three agree
    always_comb begin
        next_s    = s;
        next_s.s1 = async_i;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < W; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.lvl[i] = s.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= {INIT, INIT, INIT, INIT};
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.lvl;
endmodule

// *** psrb_charge.sv ***
// charger status encoder with low-battery termination timer
`timescale 1ns/1ps
module psrb_charge #(
    parameter logic [psrb_pkg::LOWBAT_W-1:0] LOWBAT_CYCLES = psrb_pkg::LOWBAT_CYCLES
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       charger_en_i,
    input  wire logic       cc_phase_i,
    input  wire logic       end_of_charge_i,
    input  wire logic       timer_expired_i,
    input  wire logic       temp_out_of_range_i,
    input  wire logic       battery_overtemp_i,
    input  wire logic       low_battery_i,
    output logic            charging_o,
    output logic      [1:0] fault_o,
    output logic            pause_o,
    output logic            terminate_o
);
    typedef struct packed {
        logic [psrb_pkg::LOWBAT_W-1:0] low_cnt;
        logic                          bat_fault;
        logic                          charging;
        logic [1:0]                    fault;
        logic                          pause;
        logic                          terminate;
    } psrb_charge_t;
    psrb_charge_t s;
    psrb_charge_t next_s;

    always_comb begin
        next_s = s;
        // low battery held past the limit latches a battery fault
        if (!charger_en_i) begin
            next_s.low_cnt   = '0;
            next_s.bat_fault = 1'b0;
        end else if (low_battery_i && !s.bat_fault) begin
            if (s.low_cnt >= LOWBAT_CYCLES - 1'b1) begin
                next_s.bat_fault = 1'b1;
            end else begin
                next_s.low_cnt = s.low_cnt + 1'b1;
            end
        end else if (!low_battery_i) begin
            next_s.low_cnt = '0;
        end
        // charge flag: constant-current phase, even while paused
        next_s.charging = charger_en_i && cc_phase_i && !end_of_charge_i
                          && !timer_expired_i && !s.bat_fault;
        // fault code, most severe first
        if (s.bat_fault) begin
            next_s.fault = psrb_pkg::FAULT_BATTERY;
        end else if (battery_overtemp_i) begin
            next_s.fault = psrb_pkg::FAULT_OVERTMP;
        end else if (temp_out_of_range_i) begin
            next_s.fault = psrb_pkg::FAULT_COLDHOT;
        end else begin
            next_s.fault = psrb_pkg::FAULT_NONE;
        end
        // pause follows temperature, resume is automatic
        next_s.pause     = charger_en_i && temp_out_of_range_i && !s.bat_fault;
        next_s.terminate = s.bat_fault || timer_expired_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign charging_o  = s.charging;
    assign fault_o     = s.fault;
    assign pause_o     = s.pause;
    assign terminate_o = s.terminate;
endmodule

// *** psrb_top.sv ***
// serial register bank: four control bytes written, one status byte read
`timescale 1ns/1ps
module psrb_top #(
    parameter logic [psrb_pkg::LOWBAT_W-1:0] LOWBAT_CYCLES = psrb_pkg::LOWBAT_CYCLES
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // serial bus, open drain data
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    // clear sources
    input  wire logic       supply_uvlo_i,
    input  wire logic       seq_power_down_i,
    // charger condition inputs
    input  wire logic       charger_en_i,
    input  wire logic       cc_phase_i,
    input  wire logic       end_of_charge_i,
    input  wire logic       timer_expired_i,
    input  wire logic       temp_out_of_range_i,
    input  wire logic       battery_overtemp_i,
    input  wire logic       low_battery_i,
    // regulator conditions
    input  wire logic [2:0] stepdown_on_i,
    input  wire logic [1:0] linear_reg_in_reg_i,
    input  wire logic [2:0] stepdown_in_reg_i,
    // charger control
    output logic            charge_pause_o,
    output logic            charge_terminate_o,
    // regulator control
    output logic            linear_reg1_on_o,
    output logic            linear_reg2_on_o,
    output logic            stepdown1_light_load_o,
    output logic            stepdown2_light_load_o,
    output logic            stepdown3_light_load_o,
    output logic      [1:0] stepdown_edge_rate_o,
    // backlight control
    output logic            backlight_on_o,
    output logic      [1:0] ramp_time_o,
    output logic      [1:0] backlight_op_o,
    output logic      [1:0] dim_clock_sel_o,
    output logic            backlight_edge_rate_o,
    output logic      [5:0] backlight_level_o,
    output logic      [3:0] dim_denominator_o,
    output logic      [3:0] dim_numerator_o
);
    localparam int SYNC_W = 15;
    localparam logic [SYNC_W-1:0] SYNC_INIT = 15'h6000; // bus lines idle high

    typedef struct packed {
        psrb_pkg::psrb_state_t  st;
        psrb_pkg::psrb_phase_t  ph;
        logic                   rd;
        logic [2:0]             bit_cnt;
        logic [7:0]             shift;
        logic [1:0]             sub;
        logic [7:0]             snap;
        logic                   scl_q;
        logic                   sda_q;
        logic                   sda_lo;
        logic                   oe_n;
        logic [psrb_pkg::NUM_REGS-1:0][7:0] regs;
    } psrb_top_t;
    psrb_top_t s;
    psrb_top_t next_s;

    logic [SYNC_W-1:0] sy;
    logic              scl;
    logic              sda;
    logic              clr;
    logic              chg_on;
    logic [1:0]        chg_fault;
    logic [7:0]        status;
    logic              start;
    logic              stop;
    logic              rise;
    logic              fall;
    logic [7:0]        rx_byte;

    // all outside inputs but the first two bucks' conditions pass this three-stage filter
    psrb_sync #(
        .W    (SYNC_W),
        .INIT (SYNC_INIT)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    ({scl_i, sda_i, supply_uvlo_i, seq_power_down_i, charger_en_i,
                      cc_phase_i, end_of_charge_i, timer_expired_i, temp_out_of_range_i,
                      battery_overtemp_i, low_battery_i, stepdown_on_i[2],
                      stepdown_in_reg_i[2], linear_reg_in_reg_i}),
        .level_o    (sy)
    );

    assign scl = sy[14];
    assign sda = sy[13];
    assign clr = sy[12] | sy[11];

    psrb_charge #(
        .LOWBAT_CYCLES (LOWBAT_CYCLES)
    ) u_charge (
        .core_clk_i          (core_clk_i),
        .rst_n_i             (rst_n_i),
        .charger_en_i        (sy[10]),
        .cc_phase_i          (sy[9]),
        .end_of_charge_i     (sy[8]),
        .timer_expired_i     (sy[7]),
        .temp_out_of_range_i (sy[6]),
        .battery_overtemp_i  (sy[5]),
        .low_battery_i       (sy[4]),
        .charging_o          (chg_on),
        .fault_o             (chg_fault),
        .pause_o             (charge_pause_o),
        .terminate_o         (charge_terminate_o)
    );

    // second filter for the remaining buck conditions
    logic [3:0] sy_b;
    psrb_sync #(
        .W    (4),
        .INIT (4'h0)
    ) u_sync_b (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    ({stepdown_on_i[1:0], stepdown_in_reg_i[1:0]}),
        .level_o    (sy_b)
    );

    // live status byte, 1 means condition true
    always_comb begin
        status    = 8'h00;
        status[0] = chg_on;
        status[2:1] = chg_fault;
        status[3] = s.regs[psrb_pkg::SUB_REGULATOR][psrb_pkg::RC_LDO1] & sy[0];
        status[4] = s.regs[psrb_pkg::SUB_REGULATOR][psrb_pkg::RC_LDO2] & sy[1];
        status[5] = sy_b[2] & sy_b[0];
        status[6] = sy_b[3] & sy_b[1];
        status[7] = sy[3] & sy[2];
    end

    // bus line events seen in the core clock
    assign start   = scl && s.scl_q && s.sda_q && !sda;
    assign stop    = scl && s.scl_q && !s.sda_q && sda;
    assign rise    = scl && !s.scl_q;
    assign fall    = !scl && s.scl_q;
    assign rx_byte = {s.shift[6:0], sda};

    // serial engine and register file
    always_comb begin
        next_s       = s;
        next_s.scl_q = scl;
        next_s.sda_q = sda;
        if (stop) begin
            next_s.st   = psrb_pkg::PSRB_IDLE;
            next_s.oe_n = 1'b1;
        end else if (start) begin
            next_s.st      = psrb_pkg::PSRB_RECV;
            next_s.ph      = psrb_pkg::PSRB_PH_ADDR;
            next_s.bit_cnt = 3'h0;
            next_s.oe_n    = 1'b1;
        end else begin
            unique case (s.st)
                psrb_pkg::PSRB_IDLE: begin
                    next_s.oe_n = 1'b1;
                end
                psrb_pkg::PSRB_RECV: begin
                    if (rise) begin
                        next_s.shift   = rx_byte;
                        next_s.bit_cnt = s.bit_cnt + 3'h1;
                        if (s.bit_cnt == 3'h7) begin
                            next_s.st = psrb_pkg::PSRB_ACK_DRV;
                            unique case (s.ph)
                                psrb_pkg::PSRB_PH_ADDR: begin
                                    // read address has no sub-address phase
                                    next_s.rd = (rx_byte == psrb_pkg::RD_ADDR_BYTE);
                                    if (rx_byte != psrb_pkg::RD_ADDR_BYTE
                                        && rx_byte != psrb_pkg::WR_ADDR_BYTE) begin
                                        next_s.st = psrb_pkg::PSRB_IDLE;
                                    end
                                end
                                psrb_pkg::PSRB_PH_SUB: begin
                                    next_s.sub = rx_byte[1:0];
                                    if (rx_byte > psrb_pkg::SUB_LAST) begin
                                        next_s.st = psrb_pkg::PSRB_IDLE;
                                    end
                                end
                                psrb_pkg::PSRB_PH_DATA: begin
                                end
                                psrb_pkg::PSRB_PH_DONE: begin
                                    next_s.st = psrb_pkg::PSRB_IDLE; // extra bytes refused
                                end
                            endcase
                        end
                    end
                end
                psrb_pkg::PSRB_ACK_DRV: begin
                    if (fall) begin
                        next_s.oe_n = 1'b0;
                        next_s.st   = psrb_pkg::PSRB_ACK_HOLD;
                        if (s.rd && s.ph == psrb_pkg::PSRB_PH_ADDR) begin
                            next_s.snap = status;
                        end
                        if (s.ph == psrb_pkg::PSRB_PH_DATA) begin
                            next_s.regs[s.sub] = s.shift;
                        end
                    end
                end
                psrb_pkg::PSRB_ACK_HOLD: begin
                    if (fall) begin
                        next_s.bit_cnt = 3'h0;
                        if (s.rd) begin
                            next_s.shift = s.snap;
                            next_s.oe_n  = s.snap[7];
                            next_s.st    = psrb_pkg::PSRB_SEND;
                        end else begin
                            next_s.oe_n = 1'b1;
                            next_s.st   = psrb_pkg::PSRB_RECV;
                            next_s.ph   = (s.ph == psrb_pkg::PSRB_PH_ADDR)
                                          ? psrb_pkg::PSRB_PH_SUB
                                          : (s.ph == psrb_pkg::PSRB_PH_SUB)
                                          ? psrb_pkg::PSRB_PH_DATA
                                          : psrb_pkg::PSRB_PH_DONE;
                        end
                    end
                end
                psrb_pkg::PSRB_SEND: begin
                    if (fall) begin
                        if (s.bit_cnt == 3'h7) begin
                            next_s.oe_n = 1'b1;
                            next_s.st   = psrb_pkg::PSRB_MACK;
                        end else begin
                            next_s.shift   = {s.shift[6:0], 1'b0};
                            next_s.oe_n    = s.shift[6];
                            next_s.bit_cnt = s.bit_cnt + 3'h1;
                        end
                    end
                end
                psrb_pkg::PSRB_MACK: begin
                    if (rise) begin
                        // master ack repeats the same captured byte
                        next_s.st = sda ? psrb_pkg::PSRB_IDLE : psrb_pkg::PSRB_REPEAT;
                    end
                end
                psrb_pkg::PSRB_REPEAT: begin
                    if (fall) begin
                        next_s.shift   = s.snap;
                        next_s.oe_n    = s.snap[7];
                        next_s.bit_cnt = 3'h0;
                        next_s.st      = psrb_pkg::PSRB_SEND;
                    end
                end
                default: begin
                    next_s.st = psrb_pkg::PSRB_IDLE;
                end
            endcase
        end
        // power-down clears every control byte, even mid-write
        if (clr) begin
            for (int i = 0; i < psrb_pkg::NUM_REGS; i++) begin
                next_s.regs[i] = psrb_pkg::REG_RESET;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s       <= '0;
            s.st    <= psrb_pkg::PSRB_IDLE;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
            s.oe_n  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // control outputs straight from the register file; spare bits unused
    assign sda_o                  = s.sda_lo;
    assign sda_oe_n_o             = s.oe_n;
    assign linear_reg1_on_o       = s.regs[psrb_pkg::SUB_REGULATOR][psrb_pkg::RC_LDO1];
    assign linear_reg2_on_o       = s.regs[psrb_pkg::SUB_REGULATOR][psrb_pkg::RC_LDO2];
    assign stepdown1_light_load_o = s.regs[psrb_pkg::SUB_REGULATOR][psrb_pkg::RC_LIGHT1];
    assign stepdown2_light_load_o = s.regs[psrb_pkg::SUB_REGULATOR][psrb_pkg::RC_LIGHT2];
    assign stepdown3_light_load_o = s.regs[psrb_pkg::SUB_REGULATOR][psrb_pkg::RC_LIGHT3];
    assign stepdown_edge_rate_o   =
        s.regs[psrb_pkg::SUB_REGULATOR][psrb_pkg::RC_EDGE_HI:psrb_pkg::RC_EDGE_LO];
    assign backlight_on_o         = s.regs[psrb_pkg::SUB_BACKLIGHT][psrb_pkg::BC_ON];
    assign ramp_time_o            =
        s.regs[psrb_pkg::SUB_BACKLIGHT][psrb_pkg::BC_RAMP_HI:psrb_pkg::BC_RAMP_LO];
    assign backlight_op_o         =
        s.regs[psrb_pkg::SUB_BACKLIGHT][psrb_pkg::BC_OP_HI:psrb_pkg::BC_OP_LO];
    assign dim_clock_sel_o        =
        s.regs[psrb_pkg::SUB_BACKLIGHT][psrb_pkg::BC_DIM_HI:psrb_pkg::BC_DIM_LO];
    assign backlight_edge_rate_o  = s.regs[psrb_pkg::SUB_BACKLIGHT][psrb_pkg::BC_EDGE];
    assign backlight_level_o      = s.regs[psrb_pkg::SUB_LEVEL][psrb_pkg::LV_MSB:0];
    assign dim_denominator_o      =
        s.regs[psrb_pkg::SUB_DIMMING][psrb_pkg::DM_DEN_LSB +: psrb_pkg::DM_W];
    assign dim_numerator_o        =
        s.regs[psrb_pkg::SUB_DIMMING][psrb_pkg::DM_NUM_LSB +: psrb_pkg::DM_W];
endmodule

// *** psrb_properties.sv ***
// port checks for the power register bank
`timescale 1ns/1ps
module psrb_chk (
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic       scl_i,
    input wire logic       supply_uvlo_i,
    input wire logic       seq_power_down_i,
    input wire logic       charger_en_i,
    input wire logic       temp_out_of_range_i,
    input wire logic       timer_expired_i,
    input wire logic       charge_pause_o,
    input wire logic       charge_terminate_o,
    input wire logic [5:0] backlight_level_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // clearing and idle holding of the backlight level byte
    rst_zero_a: assert property ($rose(rst_n_i) |-> backlight_level_o == 6'h00)
        else $error("level not clear after reset");
    clr_zero_a: assert property ((supply_uvlo_i || seq_power_down_i) [*8]
        |-> backlight_level_o == 6'h00) else $error("level not cleared");
    quiet_hold_a: assert property ((scl_i && !supply_uvlo_i && !seq_power_down_i) [*8]
        |=> $stable(backlight_level_o)) else $error("level moved with bus idle");
    // charger pause and termination
    pause_on_a: assert property ((charger_en_i && temp_out_of_range_i
        && !charge_terminate_o) [*8] |-> charge_pause_o) else $error("no pause");
    pause_off_a: assert property (!charger_en_i [*8] |-> !charge_pause_o)
        else $error("pause while disabled");
    pause_cool_a: assert property (!temp_out_of_range_i [*8] |-> !charge_pause_o)
        else $error("pause in valid range");
    timer_term_a: assert property (timer_expired_i [*8] |-> charge_terminate_o)
        else $error("no stop on timer");
    term_clear_a: assert property ((!charger_en_i && !timer_expired_i) [*8]
        |-> !charge_terminate_o) else $error("stop held");
endmodule
bind psrb_top psrb_chk u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
    .supply_uvlo_i(supply_uvlo_i), .seq_power_down_i(seq_power_down_i),
    .charger_en_i(charger_en_i), .temp_out_of_range_i(temp_out_of_range_i),
    .timer_expired_i(timer_expired_i), .charge_pause_o(charge_pause_o),
    .charge_terminate_o(charge_terminate_o), .backlight_level_o(backlight_level_o)
);

// *** psrb_host.sv ***
// serial bus host model, open drain data with pull-up
`timescale 1ns/1ps
module psrb_host (
    input  wire logic core_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // n quarters of the 400 ns bus period
    task automatic q(input int n);
        repeat (2 * n) @(posedge core_clk_i);
    endtask
    task automatic start;
        q(4);
        sda_o <= 1'b0;
        q(2);
        scl_o <= 1'b0;
    endtask
    task automatic stop;
        q(1);
        sda_o <= 1'b0;
        q(1);
        scl_o <= 1'b1;
        q(2);
        sda_o <= 1'b1;
    endtask
    // byte msb first plus ack bit; sampled at end of the high phase
    // low phase of six cycles outlasts the device's five-cycle answer delay
    task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r,
                        output logic ak);
        logic [8:0] s;
        s = {d, ab};
        for (int i = 8; i >= 0; i--) begin
            q(1);
            sda_o <= s[i];
            q(2);
            scl_o <= 1'b1;
            q(1);
            s[i] = sda_i;
            scl_o <= 1'b0;
        end
        r = s[8:1];
        ak = s[0];
    endtask
    // address, sub-address, data; nak bit high where not acknowledged
    task automatic wr(input logic [7:0] sub, input logic [7:0] d, output logic [2:0] nk);
        logic [7:0] r;
        start;
        xfer(psrb_pkg::WR_ADDR_BYTE, 1'b1, r, nk[2]);
        xfer(sub, 1'b1, r, nk[1]);
        xfer(d, 1'b1, r, nk[0]);
        stop;
    endtask
endmodule

// *** tb_psrb_top.sv ***
// self-checking bench for the power register bank
`timescale 1ns/1ps
module tb_psrb_top;
    localparam logic [psrb_pkg::LOWBAT_W-1:0] LOWBAT = 100;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        uvlo  = 1'b0;
    logic        pdn   = 1'b0;
    logic [14:0] cond  = 15'h0000;
    logic        scl, sda_h, sda_d, oe_n, pause, term;
    wire  [28:0] ctl;
    wire         sda_w = sda_h & (oe_n | sda_d);
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    always #25 clk = ~clk;
    psrb_host u_host (.core_clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
    psrb_top #(.LOWBAT_CYCLES(LOWBAT)) u_dut (
        .core_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
        .sda_oe_n_o(oe_n), .supply_uvlo_i(uvlo), .seq_power_down_i(pdn),
        .charger_en_i(cond[0]), .cc_phase_i(cond[1]), .end_of_charge_i(cond[2]),
        .timer_expired_i(cond[3]), .temp_out_of_range_i(cond[4]),
        .battery_overtemp_i(cond[5]), .low_battery_i(cond[6]), .stepdown_on_i(cond[9:7]),
        .linear_reg_in_reg_i(cond[11:10]), .stepdown_in_reg_i(cond[14:12]),
        .charge_pause_o(pause), .charge_terminate_o(term), .linear_reg1_on_o(ctl[0]),
        .linear_reg2_on_o(ctl[1]), .stepdown1_light_load_o(ctl[2]),
        .stepdown2_light_load_o(ctl[3]), .stepdown3_light_load_o(ctl[4]),
        .stepdown_edge_rate_o(ctl[6:5]), .backlight_on_o(ctl[7]), .ramp_time_o(ctl[9:8]),
        .backlight_op_o(ctl[11:10]), .dim_clock_sel_o(ctl[13:12]),
        .backlight_edge_rate_o(ctl[14]), .backlight_level_o(ctl[20:15]),
        .dim_denominator_o(ctl[24:21]), .dim_numerator_o(ctl[28:25]));
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic rd(input logic flip, output logic [7:0] b);
        logic nk;
        logic [7:0] f;
        u_host.start;
        u_host.xfer(psrb_pkg::RD_ADDR_BYTE, 1'b1, b, nk);
        if (flip) cond[14:12] <= 3'b000;
        u_host.xfer(8'hff, !flip, b, nk);
        if (flip) u_host.xfer(8'hff, 1'b1, f, nk);
        if (flip) chk("repeat", b, f);
        u_host.stop;
    endtask
    // every field code through every sub-address, then a refused sub-address
    task automatic t_write;
        logic [7:0] d [4];
        logic [2:0] nk;
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 4; s++) begin
                d[s] = (8'h55 * k[7:0]) ^ (8'h11 * s[7:0]);
                u_host.wr(s[7:0], d[s], nk);
                chk("write ack", 0, nk);
            end
            chk("controls", {d[3], d[2][5:0], d[1], d[0][6:0]}, ctl);
        end
        u_host.wr(8'h04, 8'h00, nk);
        chk("refused ack", 3'b011, nk);
        chk("kept", {d[3], d[2][5:0], d[1], d[0][6:0]}, ctl);
    endtask
    // status codes, pause, termination and snapshot
    task automatic t_status;
        logic [14:0] ct [4] = '{15'h7f83, 15'h7693, 15'h2ba7, 15'h000b};
        logic [7:0]  sx [4] = '{8'hf9, 8'hab, 8'h54, 8'h00};
        logic [7:0]  b;
        for (int i = 0; i < 5; i++) begin
            cond <= ct[i % 4];
            repeat (12) @(posedge clk);
            rd(i == 4, b);
            chk("status", sx[i % 4], b);
            chk("pause", i == 1, pause);
            chk("terminate", i == 3, term);
        end
        cond <= 15'h0043;
        repeat (LOWBAT + 40) @(posedge clk);
        rd(1'b0, b);
        chk("battery fault", 8'h06, b);
        cond <= 15'h0000;
    endtask
    // undervoltage and power-down clears
    task automatic t_clear;
        logic [2:0] nk;
        for (int j = 0; j < 2; j++) begin
            u_host.wr(8'h02, 8'h3f, nk);
            {pdn, uvlo} <= 2'(1 << j);
            repeat (12) @(posedge clk);
            chk("cleared", 0, ctl);
            {pdn, uvlo} <= 2'b00;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk("reset", 0, ctl);
        t_write;
        t_status;
        t_clear;
        give_verdict;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            give_verdict;
        end
    end
endmodule
